//--- hw/periph_wait_calc.sv
`timescale 1ns/1ps
module periph_wait_calc #(
   parameter int CPU_PER_FX = 4,
   parameter int CPU_PER_FXX = 1
) (
   input wire logic [periph_wait_pkg::M_FIELD_W-1:0] m,
   input wire periph_wait_pkg::wait_kind_e kind,
   output logic [periph_wait_pkg::CYC_W-1:0] total
);
   import periph_wait_pkg::*;

   // Fractions round up: the CPU is held a little longer rather than too short
   function automatic int ceil_div(input int num, input int den);
      ceil_div = (num + den - 1) / den;
   endfunction

   function automatic logic [2:0] clamp_k(input int val, input logic [2:0] lo,
                                          input logic [2:0] hi);
      if (val < int'(lo)) begin
         clamp_k = lo;
      end else if (val > int'(hi)) begin
         clamp_k = hi;
      end else begin
         clamp_k = val[2:0];
      end
   endfunction

   logic [CYC_W-1:0] unit;
   logic [2:0] k;
   int den;

   always_comb begin
      den = 0;
      unit = SYNC_BASE + CYC_W'(m);
      den = int'(unit);
      unique case (kind)
         KIND_WDT1_WR: k = clamp_k(ceil_div(WDT1_RATIO_MUL * CPU_PER_FX, den) + 1,
                                   K_WDT1_MIN, K_WDT1_MAX);
         KIND_WDT2_WR: k = K_WDT2_FIXED;
         KIND_TP_RD: k = K_TP_READ;
         KIND_TP_WR: k = clamp_k(ceil_div(TP_WRITE_RATIO_MUL * CPU_PER_FXX, den),
                                 3'h0, K_TP_WRITE_MAX);
         KIND_TMC_RMW: k = K_TMC_FIXED;
         KIND_PLAIN: k = 3'h0;
         default: k = 3'h0;
      endcase
      total = BASE_CYCLES + CYC_W'(m) + CYC_W'(unit * CYC_W'(k));
   end

endmodule

//--- hw/periph_wait_pkg.sv
package periph_wait_pkg;

   // Peripheral wait control register
   localparam logic [31:0] WAIT_REG_ADDR = 32'hFFFF_F06E;
   localparam logic [7:0] WAIT_REG_RESET = 8'h77;
   localparam int M_FIELD_LSB = 0;
   localparam int M_FIELD_W = 3;

   // Access timing in CPU clocks
   localparam logic [7:0] BASE_CYCLES = 8'h03;
   localparam logic [7:0] SYNC_BASE = 8'h02;
   localparam int CYC_W = 8;

   // Clock-ratio multipliers
   localparam logic [2:0] K_WDT1_MIN = 3'h1;
   localparam logic [2:0] K_WDT1_MAX = 3'h5;
   localparam logic [2:0] K_WDT2_FIXED = 3'h3;
   localparam logic [2:0] K_TP_READ = 3'h1;
   localparam logic [2:0] K_TP_WRITE_MAX = 3'h2;
   localparam logic [2:0] K_TMC_FIXED = 3'h1;
   localparam int WDT1_RATIO_MUL = 2;
   localparam int TP_WRITE_RATIO_MUL = 5;

   // Addresses of the peripheral registers that need clock-ratio waits
   localparam logic [31:0] WDT_ONE_MODE_ADDR = 32'hFFFF_F6C0;
   localparam logic [31:0] WDT_TWO_MODE_ADDR = 32'hFFFF_F6D0;
   localparam logic [31:0] TP_CAPCOMP_ZERO_ADDR = 32'hFFFF_F5A6;
   localparam logic [31:0] TP_CAPCOMP_ONE_ADDR = 32'hFFFF_F5A8;
   localparam logic [31:0] TP_COUNTER_ADDR = 32'hFFFF_F5AE;
   localparam logic [31:0] TIMER_CTRL_FIRST_ADDR = 32'hFFFF_F606;
   localparam logic [31:0] TIMER_CTRL_STRIDE = 32'h0000_0010;
   localparam int TIMER_CTRL_COUNT = 6;

   localparam int DATA_W = 16;

   typedef enum logic [1:0] {
      SIZE_BYTE = 2'b00,
      SIZE_HALF = 2'b01,
      SIZE_WORD = 2'b10
   } access_size_e;

   typedef enum logic [1:0] {
      BIT_SET = 2'b00,
      BIT_CLR = 2'b01,
      BIT_NOT = 2'b10
   } bit_op_e;

   typedef enum logic [2:0] {
      KIND_PLAIN = 3'b000,
      KIND_WDT1_WR = 3'b001,
      KIND_WDT2_WR = 3'b011,
      KIND_TP_RD = 3'b010,
      KIND_TP_WR = 3'b110,
      KIND_TMC_RMW = 3'b111
   } wait_kind_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } access_state_e;

   typedef struct packed {
      logic [31:0] addr;
      logic wr;
      logic rmw;
      access_size_e size;
      logic [DATA_W-1:0] wdata;
      bit_op_e bit_op;
      logic [3:0] bit_sel;
   } cpu_req_s;

   typedef struct packed {
      logic sel;
      logic wr;
      logic toggle;
      logic [31:0] addr;
      access_size_e size;
      logic [DATA_W-1:0] wdata;
   } peri_out_s;

endpackage

//--- hw/peripheral_access_wait_control.sv
`timescale 1ns/1ps
module peripheral_access_wait_control #(
   parameter int CPU_PER_FX = 4,
   parameter int CPU_PER_FXX = 1
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CPU_REQ_VALID,
   input wire periph_wait_pkg::cpu_req_s CPU_REQ,
   output logic CPU_READY,
   output logic [periph_wait_pkg::DATA_W-1:0] CPU_RDATA,
   output logic CPU_BUSY,
   output periph_wait_pkg::peri_out_s PERI_OUT,
   input wire logic [periph_wait_pkg::DATA_W-1:0] PERI_RDATA,
   input wire logic PERI_ACK_TOGGLE,
   output logic [7:0] WAIT_SETTING
);
   import periph_wait_pkg::*;

   // Sort an access into its wait class; used for the first and the write phase
   function automatic wait_kind_e classify(input logic [31:0] addr, input logic wr,
                                           input logic rmw, input logic is_tmc);
      if (rmw && wr && is_tmc) begin
         classify = KIND_TMC_RMW;
      end else if (wr && !rmw && addr == WDT_ONE_MODE_ADDR) begin
         classify = KIND_WDT1_WR;
      end else if (wr && !rmw && addr == WDT_TWO_MODE_ADDR) begin
         classify = KIND_WDT2_WR;
      end else if (!wr && (addr == TP_CAPCOMP_ZERO_ADDR || addr == TP_CAPCOMP_ONE_ADDR
                           || addr == TP_COUNTER_ADDR)) begin
         classify = KIND_TP_RD;
      end else if (wr && !rmw && (addr == TP_CAPCOMP_ZERO_ADDR
                                  || addr == TP_CAPCOMP_ONE_ADDR)) begin
         classify = KIND_TP_WR;
      end else begin
         classify = KIND_PLAIN;
      end
   endfunction

   function automatic logic [DATA_W-1:0] modify(input logic [DATA_W-1:0] val,
                                                input bit_op_e op, input logic [3:0] sel);
      logic [DATA_W-1:0] mask;
      mask = DATA_W'(1) << sel;
      unique case (op)
         BIT_SET: modify = val | mask;
         BIT_CLR: modify = val & ~mask;
         BIT_NOT: modify = val ^ mask;
         default: modify = val;
      endcase
   endfunction

   logic rst_meta_q;
   logic rst_n_q;
   logic ack_meta_q;
   logic ack_sync_q;
   access_state_e state_q;
   cpu_req_s req_q;
   wait_kind_e kind_q;
   logic [CYC_W-1:0] cnt_q;
   logic [CYC_W-1:0] phase_total;
   logic [CYC_W-1:0] next_total;
   wait_kind_e next_kind;
   logic [7:0] wait_reg_q;
   logic [DATA_W-1:0] read_hold_q;
   logic [DATA_W-1:0] read_value;
   logic to_wait_reg;
   logic byte_ok;
   logic phase_done;
   logic [M_FIELD_W-1:0] m_val;
   logic accept;
   logic access_end;
   logic ack_seen;
   logic wait_wr_en;
   logic [7:0] wait_reg_d;
   logic [TIMER_CTRL_COUNT-1:0] tmc_hit_new;
   logic [TIMER_CTRL_COUNT-1:0] tmc_hit_held;

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Acknowledge comes from the asynchronous peripheral bus clock
   // Only the second flop feeds logic; the first may still be settling
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ack_meta_q <= 1'b0;
         ack_sync_q <= 1'b0;
      end else begin
         ack_meta_q <= PERI_ACK_TOGGLE;
         ack_sync_q <= ack_meta_q;
      end
   end

   assign m_val = wait_reg_q[M_FIELD_LSB +: M_FIELD_W];
   assign to_wait_reg = (state_q == ST_IDLE) ? (CPU_REQ.addr == WAIT_REG_ADDR)
                                             : (req_q.addr == WAIT_REG_ADDR);
   assign byte_ok = (state_q == ST_IDLE) ? (CPU_REQ.size == SIZE_BYTE)
                                         : (req_q.size == SIZE_BYTE);

   // Start of an access: a request is only looked at while idle
   assign accept = (state_q == ST_IDLE) && CPU_REQ_VALID;

   // One comparator per timer control register, for the new and the held address
   for (genvar g = 0; g < TIMER_CTRL_COUNT; g++) begin
      localparam logic [31:0] TMC_ADDR = TIMER_CTRL_FIRST_ADDR + TIMER_CTRL_STRIDE * 32'(g);
      assign tmc_hit_new[g] = (CPU_REQ.addr == TMC_ADDR);
      assign tmc_hit_held[g] = (req_q.addr == TMC_ADDR);
   end

   // First phase class comes from the request; an RMW reads plainly first
   always_comb begin
      if (state_q == ST_IDLE) begin
         next_kind = (CPU_REQ.rmw || to_wait_reg) ? KIND_PLAIN
                                                  : classify(CPU_REQ.addr, CPU_REQ.wr, 1'b0,
                                                             |tmc_hit_new);
      end else begin
         next_kind = to_wait_reg ? KIND_PLAIN
                                 : classify(req_q.addr, 1'b1, req_q.rmw, |tmc_hit_held);
      end
   end

   // Wait length is worked out for the phase that is about to start
   periph_wait_calc #(
      .CPU_PER_FX(CPU_PER_FX),
      .CPU_PER_FXX(CPU_PER_FXX)
   ) u_calc (
      .m(m_val),
      .kind(next_kind),
      .total(next_total)
   );

   assign phase_total = next_total;

   // A special phase ends only once the synchronised echo matches the current strobe toggle
   assign ack_seen = (ack_sync_q == PERI_OUT.toggle);
   assign phase_done = (cnt_q == CYC_W'(1)) && (kind_q == KIND_PLAIN || ack_seen);
   // Last cycle of the whole access; an RMW read phase runs straight on
   assign access_end = (state_q != ST_IDLE) && phase_done
                       && (state_q == ST_WRITE || !req_q.rmw);
   assign read_value = to_wait_reg ? (byte_ok ? DATA_W'(wait_reg_q) : '0) : PERI_RDATA;

   // Access sequencing; the CPU stays stalled while a phase counts down
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         req_q <= '0;
         kind_q <= KIND_PLAIN;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (CPU_REQ_VALID) begin
                  req_q <= CPU_REQ;
                  kind_q <= next_kind;
                  cnt_q <= phase_total - CYC_W'(1);
                  state_q <= (CPU_REQ.wr && !CPU_REQ.rmw) ? ST_WRITE : ST_READ;
               end
            end
            ST_READ: begin
               if (phase_done) begin
                  if (req_q.rmw) begin
                     kind_q <= next_kind;
                     cnt_q <= phase_total;
                     state_q <= ST_WRITE;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end else if (cnt_q != CYC_W'(1)) begin
                  cnt_q <= cnt_q - CYC_W'(1);
               end
            end
            ST_WRITE: begin
               if (phase_done) begin
                  state_q <= ST_IDLE;
               end else if (cnt_q != CYC_W'(1)) begin
                  cnt_q <= cnt_q - CYC_W'(1);
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Read data captured at the end of the read phase
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         read_hold_q <= '0;
      end else if (state_q == ST_READ && phase_done) begin
         read_hold_q <= read_value;
      end
   end

   // Wait control register; wider accesses leave it untouched
   assign wait_wr_en = (state_q == ST_WRITE) && phase_done && to_wait_reg && byte_ok;
   always_comb begin
      wait_reg_d = wait_reg_q;
      if (wait_wr_en) begin
         if (req_q.rmw) begin
            wait_reg_d = 8'(modify(read_hold_q, req_q.bit_op, req_q.bit_sel));
         end else begin
            wait_reg_d = req_q.wdata[7:0];
         end
      end
   end

   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         wait_reg_q <= WAIT_REG_RESET;
      end else begin
         wait_reg_q <= wait_reg_d;
      end
   end

   // CPU answer: one-cycle ready, read data held until the next answer
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         CPU_READY <= 1'b0;
         CPU_RDATA <= '0;
      end else begin
         CPU_READY <= 1'b0;
         if (state_q == ST_READ && phase_done && !req_q.rmw) begin
            CPU_READY <= 1'b1;
            CPU_RDATA <= read_value;
         end else if (state_q == ST_WRITE && phase_done) begin
            CPU_READY <= 1'b1;
            // An RMW answers with the old value, as a plain read would
            if (req_q.rmw) begin
               CPU_RDATA <= read_hold_q;
            end
         end
      end
   end

   // Peripheral strobes; the toggle marks each phase for the slow side
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         PERI_OUT <= '0;
      end else begin
         if (accept && !to_wait_reg) begin
            PERI_OUT.sel <= 1'b1;
            PERI_OUT.wr <= CPU_REQ.wr && !CPU_REQ.rmw;
            PERI_OUT.toggle <= ~PERI_OUT.toggle;
            PERI_OUT.addr <= CPU_REQ.addr;
            PERI_OUT.size <= CPU_REQ.size;
            PERI_OUT.wdata <= CPU_REQ.wdata;
         end else if (state_q == ST_READ && phase_done && req_q.rmw && !to_wait_reg) begin
            PERI_OUT.wr <= 1'b1;
            PERI_OUT.toggle <= ~PERI_OUT.toggle;
            PERI_OUT.wdata <= modify(read_value, req_q.bit_op, req_q.bit_sel);
         end else if (access_end) begin
            PERI_OUT.sel <= 1'b0;
            PERI_OUT.wr <= 1'b0;
         end
      end
   end

   // Busy stands from the accept edge up to the edge that samples ready
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         CPU_BUSY <= 1'b0;
      end else begin
         CPU_BUSY <= accept || (state_q != ST_IDLE);
      end
   end

   // Output copy of the wait register, updated with it
   always_ff @(posedge CLK or negedge rst_n_q) begin
      if (!rst_n_q) begin
         WAIT_SETTING <= WAIT_REG_RESET;
      end else begin
         WAIT_SETTING <= wait_reg_d;
      end
   end

endmodule

//--- verif/periph_model.sv
`timescale 1ns/1ps
module periph_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire periph_wait_pkg::peri_out_s po,
   input wire logic [7:0] echo_dly,
   output logic [periph_wait_pkg::DATA_W-1:0] rdata,
   output logic ack,
   output logic [periph_wait_pkg::DATA_W-1:0] last_wdata
);
   import periph_wait_pkg::*;
   logic [7:0] cnt_q;
   logic [DATA_W-1:0] held_q;
   // Echo only after the set delay, so a slow peripheral really stalls the CPU
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         cnt_q <= 8'h00;
      end else if (po.toggle != ack) begin
         cnt_q <= cnt_q + 8'h01;
         if (cnt_q >= echo_dly) begin
            ack <= po.toggle;
            cnt_q <= 8'h00;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (po.sel && po.wr) begin
         last_wdata <= po.wdata;
      end
   end
   always_ff @(posedge clk) begin
      if (po.sel) begin
         held_q <= rdata;
      end
   end
   // Deselected bus shows the inverse of its last value, never a stale copy
   assign rdata = po.sel ? (po.addr[15:0] ^ 16'h5A5A) : ~held_q;
endmodule

//--- verif/peripheral_access_wait_control_bench.sv
`timescale 1ns/1ps
module peripheral_access_wait_control_bench;
   import periph_wait_pkg::*;
   localparam int FX = 4;
   localparam int FXX = 1;
   logic CLK;
   logic RST_N;
   logic CPU_REQ_VALID;
   cpu_req_s CPU_REQ;
   logic CPU_READY;
   logic [DATA_W-1:0] CPU_RDATA;
   logic CPU_BUSY;
   peri_out_s PERI_OUT;
   logic [DATA_W-1:0] PERI_RDATA;
   logic PERI_ACK_TOGGLE;
   logic [7:0] WAIT_SETTING;
   logic [7:0] echo_dly;
   logic [DATA_W-1:0] last_wdata;
   int n_fail = 0;
   int checks_done = 0;
   int c;
   int m;
   logic [15:0] d;
   logic [31:0] a;
   logic [31:0] sa [10];
   int st [10];
   logic [9:0] sw = 10'h2E3;
   logic [7:0] ms [3] = '{8'h07, 8'h01, 8'hFA};
   bit_op_e ops [3] = '{BIT_SET, BIT_CLR, BIT_NOT};
   logic [15:0] rmw_exp [3] = '{16'h6A7A, 16'h6A5A, 16'h6A7A};

   peripheral_access_wait_control #(.CPU_PER_FX(FX), .CPU_PER_FXX(FXX))
      peripheral_access_wait_control_inst (.CLK(CLK), .RST_N(RST_N),
      .CPU_REQ_VALID(CPU_REQ_VALID), .CPU_REQ(CPU_REQ), .CPU_READY(CPU_READY),
      .CPU_RDATA(CPU_RDATA), .CPU_BUSY(CPU_BUSY), .PERI_OUT(PERI_OUT), .PERI_RDATA(PERI_RDATA),
      .PERI_ACK_TOGGLE(PERI_ACK_TOGGLE), .WAIT_SETTING(WAIT_SETTING));
   periph_model periph_model_inst (.clk(CLK), .rst_n(RST_N), .po(PERI_OUT), .echo_dly(echo_dly),
      .rdata(PERI_RDATA), .ack(PERI_ACK_TOGGLE), .last_wdata(last_wdata));

   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // Rounds up, as the whole-unit wait count needs
   function automatic int kf(input int t, input int mv);
      int k;
      k = 0;
      if (t == 1) k = (2 * FX + 1 + mv) / (2 + mv) + 1;
      if (t == 1 && k > 5) k = 5;
      if (t == 2) k = 3;
      if (t == 3) k = 1;
      if (t == 4) k = (5 * FXX + 1 + mv) / (2 + mv);
      if (t == 4 && k > 2) k = 2;
      return k;
   endfunction

   task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_cyc(input string n, input int e, input int g);
      checks_done++;
      if (g != e) begin
         n_fail++;
         $display("[FAIL] %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic end_test(input string n);
      $display("test %s done", n);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // Counts clock edges from the accept edge to the edge that raises ready
   task automatic acc(input logic [31:0] ad, input logic w, input logic r, input access_size_e sz,
      input logic [15:0] wd, input bit_op_e op, input logic [3:0] bs, output int cy,
      output logic [15:0] rd);
      cpu_req_s q;
      q = '{addr: ad, wr: w, rmw: r, size: sz, wdata: wd, bit_op: op, bit_sel: bs};
      @(negedge CLK);
      CPU_REQ <= q;
      CPU_REQ_VALID <= 1'b1;
      @(negedge CLK);
      CPU_REQ_VALID <= 1'b0;
      cy = 1;
      while (CPU_READY !== 1'b1 && cy < 400) begin
         @(negedge CLK);
         cy++;
      end
      rd = CPU_RDATA;
   endtask

   task automatic setw(input logic [7:0] v);
      acc(WAIT_REG_ADDR, 1'b1, 1'b0, SIZE_BYTE, {8'h00, v}, BIT_SET, 4'h0, c, d);
   endtask

   initial begin
      repeat (20000) @(posedge CLK);
      n_fail++;
      print_verdict();
   end

   initial begin
      RST_N = 1'b0;
      CPU_REQ_VALID = 1'b0;
      CPU_REQ = '0;
      echo_dly = 8'h00;
      sa = '{WDT_ONE_MODE_ADDR, WDT_TWO_MODE_ADDR, TP_CAPCOMP_ZERO_ADDR, TP_CAPCOMP_ONE_ADDR,
         TP_COUNTER_ADDR, TP_CAPCOMP_ONE_ADDR, TP_CAPCOMP_ZERO_ADDR, TP_COUNTER_ADDR,
         WDT_ONE_MODE_ADDR, TIMER_CTRL_FIRST_ADDR};
      st = '{1, 2, 3, 3, 3, 4, 4, 0, 0, 0};
      repeat (6) @(posedge CLK);
      @(negedge CLK);
      RST_N = 1'b1;
      repeat (3) @(posedge CLK);
      chk_val("wait_reset", 16'h0077, {8'h00, WAIT_SETTING});
      acc(WAIT_REG_ADDR, 1'b0, 1'b0, SIZE_BYTE, 16'h0000, BIT_SET, 4'h0, c, d);
      chk_val("wait_read", 16'h0077, {8'h00, d[7:0]});
      chk_cyc("wait_read_cycles", 10, c);
      acc(32'h0000_1000, 1'b0, 1'b0, SIZE_HALF, 16'h0000, BIT_SET, 4'h0, c, d);
      chk_cyc("plain_reset_cycles", 10, c);
      chk_val("plain_rdata", 16'h4A5A, d);
      end_test("reset_state");
      setw(8'h00);
      chk_val("wait_zero", 16'h0000, {8'h00, WAIT_SETTING});
      acc(32'h0000_2000, 1'b1, 1'b0, SIZE_HALF, 16'hBEEF, BIT_SET, 4'h0, c, d);
      chk_cyc("nowait_write_cycles", 3, c);
      chk_val("nowait_wdata", 16'hBEEF, last_wdata);
      setw(8'h01);
      acc(32'h0000_1000, 1'b0, 1'b0, SIZE_HALF, 16'h0000, BIT_SET, 4'h0, c, d);
      chk_cyc("onewait_read_cycles", 4, c);
      acc(WAIT_REG_ADDR, 1'b1, 1'b0, SIZE_HALF, 16'h0005, BIT_SET, 4'h0, c, d);
      chk_val("wait_half_write", 16'h0001, {8'h00, WAIT_SETTING});
      acc(WAIT_REG_ADDR, 1'b0, 1'b0, SIZE_HALF, 16'h0000, BIT_SET, 4'h0, c, d);
      chk_val("wait_half_read", 16'h0000, d);
      end_test("wait_setting");
      foreach (ms[j]) begin
         setw(ms[j]);
         m = int'(ms[j][2:0]);
         for (int i = 0; i < 10; i++) begin
            acc(sa[i], sw[i], 1'b0, SIZE_HALF, sa[i][15:0] ^ 16'h00FF, BIT_SET, 4'h0, c, d);
            chk_cyc("special_cycles", 3 + m + (2 + m) * kf(st[i], m), c);
            if (sw[i]) chk_val("special_wdata", sa[i][15:0] ^ 16'h00FF, last_wdata);
            else chk_val("special_rdata", sa[i][15:0] ^ 16'h5A5A, d);
         end
      end
      end_test("special_registers");
      setw(8'h01);
      for (int i = 0; i < TIMER_CTRL_COUNT; i++) begin
         a = TIMER_CTRL_FIRST_ADDR + TIMER_CTRL_STRIDE * i;
         acc(a, 1'b1, 1'b1, SIZE_HALF, 16'h0000, BIT_SET, 4'h3, c, d);
         chk_cyc("timer_rmw_cycles", 11, c);
         chk_val("timer_rmw_old", a[15:0] ^ 16'h5A5A, d);
         chk_val("timer_rmw_new", (a[15:0] ^ 16'h5A5A) | 16'h0008, last_wdata);
      end
      foreach (ops[i]) begin
         acc(32'h0000_3000, 1'b1, 1'b1, SIZE_HALF, 16'h0000, ops[i], 4'h5, c, d);
         chk_cyc("plain_rmw_cycles", 8, c);
         chk_val("plain_rmw_new", rmw_exp[i], last_wdata);
      end
      end_test("read_modify_write");
      // A slow echo must stretch the access past its nominal length
      echo_dly = 8'd30;
      acc(TP_CAPCOMP_ZERO_ADDR, 1'b1, 1'b0, SIZE_HALF, 16'h1234, BIT_SET, 4'h0, c, d);
      chk_val("slow_echo_stretch", 16'h0001, {15'h0000, c > 30});
      echo_dly = 8'h00;
      end_test("slow_peripheral");
      print_verdict();
   end
endmodule

//--- verif/peripheral_access_wait_control_sva.sv
`timescale 1ns/1ps
module peripheral_access_wait_control_sva #(
   parameter int CPU_PER_FX = 4,
   parameter int CPU_PER_FXX = 1
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CPU_REQ_VALID,
   input wire periph_wait_pkg::cpu_req_s CPU_REQ,
   input wire logic CPU_READY,
   input wire logic [periph_wait_pkg::DATA_W-1:0] CPU_RDATA,
   input wire logic CPU_BUSY,
   input wire periph_wait_pkg::peri_out_s PERI_OUT,
   input wire logic [periph_wait_pkg::DATA_W-1:0] PERI_RDATA,
   input wire logic PERI_ACK_TOGGLE,
   input wire logic [7:0] WAIT_SETTING
);
   import periph_wait_pkg::*;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);
   logic take;
   logic plain;
   logic [2:0] m;
   assign take = CPU_REQ_VALID && (!CPU_BUSY || CPU_READY);
   // Special registers all sit in the top page, the wait register too
   assign plain = (CPU_REQ.addr[31:12] != 20'hFFFFF) && !CPU_REQ.rmw;
   assign m = WAIT_SETTING[2:0];
   ready_pulse_a: assert property (CPU_READY |=> !CPU_READY)
      else $error("ready held longer than one cycle");
   busy_hold_a: assert property (CPU_BUSY && !CPU_READY |=> CPU_BUSY)
      else $error("busy dropped before ready");
   accept_busy_a: assert property (take |=> CPU_BUSY && !CPU_READY)
      else $error("accepted access not busy or answered too soon");
   plain_nowait_a: assert property (take && plain && m == 3'h0
      |=> !CPU_READY [*2] ##1 CPU_READY)
      else $error("plain access with no wait not three cycles");
   plain_onewait_a: assert property (take && plain && m == 3'h1
      |=> !CPU_READY [*3] ##1 CPU_READY)
      else $error("plain access with one wait not four cycles");
   plain_reset_a: assert property (take && plain && m == 3'h7 |-> ##10 CPU_READY)
      else $error("plain access at reset wait not ten cycles");
   wdt_two_a: assert property (take && CPU_REQ.wr && !CPU_REQ.rmw
      && CPU_REQ.addr == WDT_TWO_MODE_ADDR && m == 3'h7 |-> ##37 CPU_READY)
      else $error("watchdog two write length wrong");
   timer_rmw_a: assert property (take && CPU_REQ.rmw
      && CPU_REQ.addr == TIMER_CTRL_FIRST_ADDR && m == 3'h1 |-> ##11 CPU_READY)
      else $error("timer control rmw length wrong");
   sel_busy_a: assert property (PERI_OUT.sel |-> CPU_BUSY)
      else $error("peripheral select outside an access");
   rdata_hold_a: assert property ($changed(CPU_RDATA) |-> CPU_READY)
      else $error("read data changed without ready");
   wait_hold_a: assert property ($changed(WAIT_SETTING) |-> CPU_BUSY || $past(CPU_BUSY))
      else $error("wait setting changed outside an access");
endmodule
bind peripheral_access_wait_control peripheral_access_wait_control_sva #(
   .CPU_PER_FX(CPU_PER_FX),
   .CPU_PER_FXX(CPU_PER_FXX)
) peripheral_access_wait_control_sva_inst (.CLK(CLK), .RST_N(RST_N),
   .CPU_REQ_VALID(CPU_REQ_VALID), .CPU_REQ(CPU_REQ), .CPU_READY(CPU_READY),
   .CPU_RDATA(CPU_RDATA), .CPU_BUSY(CPU_BUSY), .PERI_OUT(PERI_OUT), .PERI_RDATA(PERI_RDATA),
   .PERI_ACK_TOGGLE(PERI_ACK_TOGGLE), .WAIT_SETTING(WAIT_SETTING));
